//--- design/reset_timeout_and_cause_flags.sv
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_and_cause_flags
  import rst_seq_pkg::*;
#(
  parameter int SLOW_TICK_CYCLES = SLOW_OSC_CYCLES,
  parameter int PLL_CYCLES = PLL_LOCK_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire osc_mode_e I_OSC_MODE,
  input wire logic I_POWER_DELAY_DISABLE_CFG,
  input wire logic I_STACK_ERROR_RESET_EN,
  input wire logic [1:0] I_BROWNOUT_MODE_CFG,
  input wire logic I_OSC_TICK,
  input wire logic I_EXTERNAL_RESET_PIN_N,
  input wire logic I_BROWNOUT_DETECT,
  input wire logic I_RESET_INSTR,
  input wire logic I_WATCHDOG_TIMEOUT,
  input wire logic I_STACK_FULL,
  input wire logic I_STACK_UNDERFLOW,
  input wire logic I_INT_WAKE,
  input wire pwr_mode_e I_PWR_MODE,
  input wire logic I_GLOBAL_INT_ENABLE_HIGH,
  input wire logic I_GLOBAL_INT_ENABLE_LOW,
  input wire logic [PC_W-1:0] I_PC,
  input wire logic I_FLAGS_WR,
  input wire cause_flags_s I_FLAGS_WDATA,
  input wire logic I_SW_BROWNOUT_WR,
  input wire logic I_SW_BROWNOUT_WDATA,
  input wire logic I_SCRATCH_WR,
  input wire logic [7:0] I_SCRATCH_WDATA,
  output logic O_CORE_RST,
  output logic O_CORE_STALL,
  output logic O_PC_LOAD,
  output logic [PC_W-1:0] O_PC_VALUE,
  output cause_flags_s O_CAUSE_FLAGS,
  output logic O_SW_BROWNOUT_ENABLE,
  output logic [7:0] O_SCRATCH
);

  // sequencer state
  seq_state_e state_ff; // current time-out stage
  seq_state_e nxt_state;
  logic seq_reset_ff; // stage holds core in reset, else only stalls
  logic nxt_seq_reset;

  // event tracking and status
  logic pin_q_ff; // pin level one cycle ago, for edge detect
  logic nxt_pin_q;
  logic brownout_q_ff; // brown-out level one cycle ago
  logic nxt_brownout_q;
  cause_flags_s flags_ff; // reset-cause and stack flags
  cause_flags_s nxt_flags;
  logic [PC_W-1:0] pc_ff; // vector handed to the core
  logic [PC_W-1:0] nxt_pc;
  logic pc_load_ff; // one-cycle load strobe
  logic nxt_pc_load;
  logic rst_pulse_ff; // one-cycle core reset for event resets
  logic nxt_rst_pulse;
  logic sw_brownout_ff; // software brown-out enable store
  logic nxt_sw_brownout;
  logic wake_req; // wake from low power, no reset

  // register without a reset value
  logic [7:0] scratch_ff;
  logic [7:0] nxt_scratch;

  // counter control
  logic stage_start; // load stage counter this cycle
  logic [CNT_W-1:0] stage_load;
  logic stage_tick; // count enable for the running stage
  logic stage_expired;
  logic slow_tick; // slow internal oscillator period strobe

  // derived conditions
  logic brownout_active; // detector gated by its configuration
  logic pin_fall; // external reset pin just went low
  logic low_power; // idle or sleep

  assign low_power = is_low_power(I_PWR_MODE);
  assign pin_fall = pin_q_ff && !I_EXTERNAL_RESET_PIN_N;

  // brown-out gating follows the configuration code
  always_comb begin
    unique case (I_BROWNOUT_MODE_CFG)
      BROWNOUT_CFG_OFF: brownout_active = 1'b0;
      BROWNOUT_CFG_SW: brownout_active = I_BROWNOUT_DETECT && sw_brownout_ff;
      BROWNOUT_CFG_NO_SLEEP: brownout_active = I_BROWNOUT_DETECT && I_PWR_MODE != PWR_SLEEP;
      BROWNOUT_CFG_ON: brownout_active = I_BROWNOUT_DETECT;
    endcase
  end

  // slow oscillator stand-in; restarted with each stage for whole periods
  tick_divider #(
    .PERIOD(SLOW_TICK_CYCLES)
  ) u_slow_tick (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_clear(stage_start),
    .o_tick(slow_tick)
  );

  // one counter shared by all stages, since they never overlap
  stage_counter u_stage (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_start(stage_start),
    .i_load(stage_load),
    .i_tick(stage_tick),
    .o_expired(stage_expired)
  );

  // tick source follows the stage being timed
  always_comb begin
    unique case (state_ff)
      ST_PWR_DELAY: stage_tick = slow_tick;
      ST_OSC_STARTUP: stage_tick = I_OSC_TICK;
      ST_PLL_LOCK: stage_tick = 1'b1;
      default: stage_tick = 1'b0;
    endcase
  end

  // sequencer next state; the pin never enters here, so
  // the stages may finish while it is still low
  always_comb begin
    nxt_state = state_ff;
    nxt_seq_reset = seq_reset_ff;
    stage_start = 1'b0;
    stage_load = '0;
    if (brownout_active) begin
      // brown-out restarts the whole power-up sequence
      nxt_state = ST_HOLD;
      nxt_seq_reset = 1'b1;
    end else begin
      unique case (state_ff)
        ST_HOLD: begin
          stage_start = 1'b1;
          if (!I_POWER_DELAY_DISABLE_CFG) begin
            nxt_state = ST_PWR_DELAY;
            stage_load = PWR_DELAY_TICKS;
          end else if (needs_startup(I_OSC_MODE)) begin
            nxt_state = ST_OSC_STARTUP;
            stage_load = OSC_STARTUP_PERIODS;
          end else begin
            // no stage applies: release straight away
            nxt_state = ST_RUN;
            stage_start = 1'b0;
          end
        end
        ST_PWR_DELAY: begin
          if (stage_expired) begin
            if (needs_startup(I_OSC_MODE)) begin
              nxt_state = ST_OSC_STARTUP;
              stage_start = 1'b1;
              stage_load = OSC_STARTUP_PERIODS;
            end else begin
              nxt_state = ST_RUN;
            end
          end
        end
        ST_OSC_STARTUP: begin
          if (stage_expired) begin
            if (needs_pll(I_OSC_MODE)) begin
              nxt_state = ST_PLL_LOCK;
              stage_start = 1'b1;
              stage_load = CNT_W'(PLL_CYCLES);
            end else begin
              nxt_state = ST_RUN;
            end
          end
        end
        ST_PLL_LOCK: begin
          if (stage_expired) begin
            nxt_state = ST_RUN;
          end
        end
        ST_RUN: begin
          // leaving low power re-times the crystal, core only stalls
          if (wake_req && needs_startup(I_OSC_MODE)) begin
            nxt_state = ST_OSC_STARTUP;
            nxt_seq_reset = 1'b0;
            stage_start = 1'b1;
            stage_load = OSC_STARTUP_PERIODS;
          end else begin
            nxt_seq_reset = 1'b0;
          end
        end
        default: begin
          nxt_state = ST_HOLD;
          nxt_seq_reset = 1'b1;
        end
      endcase
    end
  end

  // async reset is the end of the power-on pulse
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_ff <= ST_HOLD;
      seq_reset_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      seq_reset_ff <= nxt_seq_reset;
    end
  end

  // event decode: software writes first, hardware events after,
  // so an event in the cycle of a clear still lands.
  // priority: brown-out, pin, watchdog, stack, instr, interrupt.
  always_comb begin
    nxt_pin_q = I_EXTERNAL_RESET_PIN_N;
    nxt_brownout_q = brownout_active;
    nxt_flags = flags_ff;
    nxt_pc = pc_ff;
    nxt_pc_load = 1'b0;
    nxt_rst_pulse = 1'b0;
    wake_req = 1'b0;
    nxt_sw_brownout = sw_brownout_ff;
    if (I_FLAGS_WR) begin
      nxt_flags = I_FLAGS_WDATA;
    end
    if (I_SW_BROWNOUT_WR) begin
      nxt_sw_brownout = I_SW_BROWNOUT_WDATA;
    end
    if (brownout_active && !brownout_q_ff) begin
      nxt_flags.reset_instr_flag = 1'b1;
      nxt_flags.watchdog_timeout_flag = 1'b1;
      nxt_flags.power_down_flag = 1'b1;
      nxt_flags.brown_out_flag = 1'b0;
      nxt_rst_pulse = 1'b1;
    end else if (pin_fall) begin
      nxt_rst_pulse = 1'b1;
      unique case (I_PWR_MODE)
        PWR_FULL: ;
        PWR_RUN: nxt_flags.watchdog_timeout_flag = 1'b1;
        PWR_IDLE, PWR_SLEEP: begin
          nxt_flags.watchdog_timeout_flag = 1'b1;
          nxt_flags.power_down_flag = 1'b0;
        end
      endcase
    end else if (I_WATCHDOG_TIMEOUT) begin
      nxt_flags.watchdog_timeout_flag = 1'b0;
      if (low_power) begin
        // wake, not reset: registers keep their contents
        nxt_flags.power_down_flag = 1'b0;
        wake_req = 1'b1;
      end else begin
        nxt_rst_pulse = 1'b1;
      end
    end else if (I_STACK_FULL && I_STACK_ERROR_RESET_EN) begin
      nxt_flags.stack_full_flag = 1'b1;
      nxt_rst_pulse = 1'b1;
    end else if (I_STACK_UNDERFLOW) begin
      nxt_flags.stack_underflow_flag = 1'b1;
      nxt_rst_pulse = I_STACK_ERROR_RESET_EN;
    end else if (I_RESET_INSTR) begin
      nxt_flags.reset_instr_flag = 1'b0;
      nxt_rst_pulse = 1'b1;
    end else if (I_INT_WAKE && low_power) begin
      nxt_flags.power_down_flag = 1'b0;
      wake_req = 1'b1;
    end
    // vector choice, made in the detection cycle, presented with the load strobe the cycle after
    if (nxt_rst_pulse) begin
      nxt_pc = RESET_VECTOR;
      nxt_pc_load = 1'b1;
      // enable survives only in software brown-out mode
      if (I_BROWNOUT_MODE_CFG != BROWNOUT_CFG_SW) begin
        nxt_sw_brownout = 1'b0;
      end
    end else if (wake_req) begin
      nxt_pc_load = 1'b1;
      if (I_INT_WAKE && I_GLOBAL_INT_ENABLE_HIGH) begin
        nxt_pc = INT_VECTOR_HIGH;
      end else if (I_INT_WAKE && I_GLOBAL_INT_ENABLE_LOW) begin
        nxt_pc = INT_VECTOR_LOW;
      end else begin
        nxt_pc = I_PC + PC_WAKE_STEP;
      end
    end
  end

  // power-on values are constants; the cause pattern is fixed
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_q_ff <= 1'b0; // a pin held low through power-on is no fall
      brownout_q_ff <= 1'b0;
      flags_ff <= POR_FLAGS;
      pc_ff <= RESET_VECTOR;
      pc_load_ff <= 1'b0;
      rst_pulse_ff <= 1'b0;
      sw_brownout_ff <= 1'b1;
    end else begin
      pin_q_ff <= nxt_pin_q;
      brownout_q_ff <= nxt_brownout_q;
      flags_ff <= nxt_flags;
      pc_ff <= nxt_pc;
      pc_load_ff <= nxt_pc_load;
      rst_pulse_ff <= nxt_rst_pulse;
      sw_brownout_ff <= nxt_sw_brownout;
    end
  end

  // scratch storage with no reset value
  always_comb begin
    nxt_scratch = I_SCRATCH_WR ? I_SCRATCH_WDATA : scratch_ff;
  end

  // left out of the reset on purpose: unknown at power-on, kept after
  always_ff @(posedge I_REF_CLK) begin
    scratch_ff <= nxt_scratch;
  end

  // combinational release so a rising pin starts code with no delay
  assign O_CORE_RST = (state_ff != ST_RUN && seq_reset_ff)
                      || !I_EXTERNAL_RESET_PIN_N
                      || rst_pulse_ff;
  assign O_CORE_STALL = state_ff != ST_RUN && !seq_reset_ff;
  assign O_PC_LOAD = pc_load_ff;
  assign O_PC_VALUE = pc_ff;
  assign O_CAUSE_FLAGS = flags_ff;
  // reads as zero outside software brown-out mode
  assign O_SW_BROWNOUT_ENABLE = sw_brownout_ff && I_BROWNOUT_MODE_CFG == BROWNOUT_CFG_SW;
  assign O_SCRATCH = scratch_ff;

endmodule
`default_nettype wire

//--- design/rst_seq_pkg.sv
package rst_seq_pkg;

  // program counter and vectors
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
  localparam logic [PC_W-1:0] INT_VECTOR_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] INT_VECTOR_LOW = 21'h000018;
  localparam logic [PC_W-1:0] PC_WAKE_STEP = 21'h000002;

  // reference clock
  localparam int CLK_PERIOD_NS = 10;

  // stage counter width, large enough for the lock delay in cycles
  localparam int CNT_W = 18;

  // power-up delay: 11-bit count of slow internal oscillator periods
  localparam int SLOW_OSC_PERIOD_NS = 32000;
  localparam int SLOW_OSC_CYCLES = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] PWR_DELAY_TICKS = 18'h00800;

  // oscillator start-up: periods of the main oscillator
  localparam logic [CNT_W-1:0] OSC_STARTUP_PERIODS = 18'h00400;

  // pll lock delay, a least time, so rounded up
  localparam int PLL_LOCK_NS = 2000000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // brown-out configuration codes
  localparam logic [1:0] BROWNOUT_CFG_OFF = 2'h0;
  localparam logic [1:0] BROWNOUT_CFG_SW = 2'h1;
  localparam logic [1:0] BROWNOUT_CFG_NO_SLEEP = 2'h2;
  localparam logic [1:0] BROWNOUT_CFG_ON = 2'h3;

  typedef enum logic [3:0] {
    crystal_pll_osc_mode,
    high_speed_crystal_mode,
    crystal_osc_mode,
    low_power_crystal_mode,
    external_clock_mode,
    external_clock_io_mode,
    rc_osc_mode,
    rc_osc_io_mode,
    internal_osc_mode_a,
    internal_osc_mode_b
  } osc_mode_e;

  typedef enum logic [1:0] {
    PWR_FULL,
    PWR_RUN,
    PWR_IDLE,
    PWR_SLEEP
  } pwr_mode_e;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_PWR_DELAY,
    ST_OSC_STARTUP,
    ST_PLL_LOCK,
    ST_RUN
  } seq_state_e;

  // reset-cause and stack status flags
  typedef struct packed {
    logic reset_instr_flag;
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic power_on_flag;
    logic brown_out_flag;
    logic stack_full_flag;
    logic stack_underflow_flag;
  } cause_flags_s;

  // instr, timeout, power-down set; the rest cleared
  localparam cause_flags_s POR_FLAGS = 7'h70;

  // crystal, resonator and pll modes need the start-up count
  function automatic logic needs_startup(input osc_mode_e mode);
    return mode inside {crystal_pll_osc_mode, high_speed_crystal_mode,
                        crystal_osc_mode, low_power_crystal_mode};
  endfunction

  function automatic logic needs_pll(input osc_mode_e mode);
    return mode == crystal_pll_osc_mode;
  endfunction

  function automatic logic is_low_power(input pwr_mode_e mode);
    return mode inside {PWR_IDLE, PWR_SLEEP};
  endfunction

endpackage

//--- design/stage_counter.sv
`timescale 1ns/1ns
`default_nettype none
module stage_counter
  import rst_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_load,
  input wire logic i_tick,
  output logic o_expired
);

  logic [CNT_W-1:0] cnt_ff; // ticks left in the stage
  logic [CNT_W-1:0] nxt_cnt;

  // load on start, count down on each tick, stop at zero
  always_comb begin
    if (i_start) begin
      nxt_cnt = i_load;
    end else if (i_tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // a fresh load is never zero, so no false expiry on entry
  assign o_expired = (cnt_ff == '0);

endmodule
`default_nettype wire

//--- design/tick_divider.sv
`timescale 1ns/1ns
`default_nettype none
module tick_divider
  import rst_seq_pkg::*;
#(
  parameter int PERIOD = SLOW_OSC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  output logic o_tick
);

  logic [CNT_W-1:0] cnt_ff; // cycles left in this period
  logic [CNT_W-1:0] nxt_cnt;

  // reload on clear or wrap so every period is whole
  always_comb begin
    if (i_clear || cnt_ff == '0) begin
      nxt_cnt = CNT_W'(PERIOD - 1);
    end else begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // one-cycle enable at the end of each period
  assign o_tick = (cnt_ff == '0) && !i_clear;

endmodule
`default_nettype wire

//--- testbench/reset_pin_driver.sv
`timescale 1ns/1ns
`default_nettype none
// far side: whoever pulls the external reset pin low
module reset_pin_driver (
  input wire logic i_clk,
  input wire logic i_hold,
  output logic o_pin_n
);
  // pull-up on the pin, so a released pin reads high; the pin is not tied
  // to the power-on pulse, so a hold from the start keeps it low throughout
  always_ff @(posedge i_clk) begin
    o_pin_n <= ~i_hold;
  end
endmodule
`default_nettype wire

//--- testbench/reset_timeout_and_cause_flags_checker.sv
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_and_cause_flags_checker
  import rst_seq_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_STACK_ERROR_RESET_EN,
  input wire logic I_EXTERNAL_RESET_PIN_N,
  input wire logic I_BROWNOUT_DETECT,
  input wire logic [1:0] I_BROWNOUT_MODE_CFG,
  input wire logic I_RESET_INSTR,
  input wire logic I_WATCHDOG_TIMEOUT,
  input wire logic I_STACK_FULL,
  input wire logic I_STACK_UNDERFLOW,
  input wire logic I_INT_WAKE,
  input wire pwr_mode_e I_PWR_MODE,
  input wire logic I_GLOBAL_INT_ENABLE_HIGH,
  input wire logic [PC_W-1:0] I_PC,
  input wire logic I_FLAGS_WR,
  input wire logic O_CORE_RST,
  input wire logic O_PC_LOAD,
  input wire logic [PC_W-1:0] O_PC_VALUE,
  input wire logic O_SW_BROWNOUT_ENABLE,
  input wire cause_flags_s O_CAUSE_FLAGS
);
  logic pin_ff; // pin one cycle back
  // reset low: a pin held low through reset is not a fall
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST)
      pin_ff <= 1'b0;
    else
      pin_ff <= I_EXTERNAL_RESET_PIN_N;
  end
  // priority masks: nothing stronger in the same cycle
  wire logic pin_fall = pin_ff & ~I_EXTERNAL_RESET_PIN_N;
  wire logic q_wdt = ~I_BROWNOUT_DETECT & ~pin_fall;
  wire logic q_stk = q_wdt & ~I_WATCHDOG_TIMEOUT;
  wire logic q_unf = q_stk & ~(I_STACK_FULL & I_STACK_ERROR_RESET_EN);
  wire logic q_ri = q_unf & ~I_STACK_UNDERFLOW;
  wire logic q_all = q_ri & ~I_RESET_INSTR & ~I_INT_WAKE & ~I_STACK_FULL & ~I_FLAGS_WR;
  wire logic low_pwr = (I_PWR_MODE == PWR_IDLE) || (I_PWR_MODE == PWR_SLEEP);
  // detector only counts where its configuration lets it act
  wire logic bod_on = I_BROWNOUT_DETECT && (I_BROWNOUT_MODE_CFG == BROWNOUT_CFG_ON ||
    (I_BROWNOUT_MODE_CFG == BROWNOUT_CFG_NO_SLEEP && I_PWR_MODE != PWR_SLEEP) ||
    O_SW_BROWNOUT_ENABLE);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_pin_holds_core: assert property (!I_EXTERNAL_RESET_PIN_N |-> O_CORE_RST)
    else $error("core ran with reset pin low");
  a_bod_holds_core: assert property (bod_on |=> O_CORE_RST)
    else $error("core ran during brown-out");
  a_rst_instr_flag: assert property (I_RESET_INSTR && q_ri |=> O_PC_LOAD &&
    O_PC_VALUE == RESET_VECTOR && !O_CAUSE_FLAGS.reset_instr_flag)
    else $error("reset instruction answer wrong");
  a_wdt_wake_pc: assert property (I_WATCHDOG_TIMEOUT && q_wdt && low_pwr |=> O_PC_LOAD &&
    O_PC_VALUE == $past(I_PC) + PC_WAKE_STEP && !O_CAUSE_FLAGS.watchdog_timeout_flag &&
    !O_CAUSE_FLAGS.power_down_flag)
    else $error("watchdog wake answer wrong");
  a_wdt_run_reset: assert property (I_WATCHDOG_TIMEOUT && q_wdt && !low_pwr |=> O_CORE_RST &&
    O_PC_VALUE == RESET_VECTOR && !O_CAUSE_FLAGS.watchdog_timeout_flag)
    else $error("watchdog reset answer wrong");
  a_stack_full_rst: assert property (I_STACK_FULL && I_STACK_ERROR_RESET_EN && q_stk
    |=> O_CORE_RST && O_CAUSE_FLAGS.stack_full_flag)
    else $error("stack full reset wrong");
  a_unf_no_reset: assert property (I_STACK_UNDERFLOW && !I_STACK_ERROR_RESET_EN && q_unf &&
    !O_CORE_RST && I_EXTERNAL_RESET_PIN_N ##1 I_EXTERNAL_RESET_PIN_N
    |-> O_CAUSE_FLAGS.stack_underflow_flag && !O_CORE_RST)
    else $error("underflow error acted as reset");
  a_int_high_vec: assert property (I_INT_WAKE && q_ri && !I_RESET_INSTR && low_pwr &&
    I_GLOBAL_INT_ENABLE_HIGH |=> O_PC_VALUE == INT_VECTOR_HIGH && !O_CAUSE_FLAGS.power_down_flag)
    else $error("interrupt wake vector wrong");
  a_flags_hold: assert property (q_all |=> $stable(O_CAUSE_FLAGS))
    else $error("cause flags moved with no event");
  c_wdt_wake: cover property (I_WATCHDOG_TIMEOUT && q_wdt && low_pwr);
  c_int_wake: cover property (I_INT_WAKE && low_pwr ##1 O_PC_LOAD);
  c_pin_release: cover property ($rose(I_EXTERNAL_RESET_PIN_N) && !O_CORE_RST);
endmodule
bind reset_timeout_and_cause_flags reset_timeout_and_cause_flags_checker chk (.I_REF_CLK,
  .I_SYS_RST, .I_STACK_ERROR_RESET_EN, .I_EXTERNAL_RESET_PIN_N, .I_BROWNOUT_DETECT,
  .I_RESET_INSTR, .I_WATCHDOG_TIMEOUT, .I_STACK_FULL, .I_STACK_UNDERFLOW, .I_INT_WAKE,
  .I_PWR_MODE, .I_GLOBAL_INT_ENABLE_HIGH, .I_PC, .I_FLAGS_WR, .O_CORE_RST, .O_PC_LOAD,
  .O_PC_VALUE, .O_CAUSE_FLAGS, .I_BROWNOUT_MODE_CFG, .O_SW_BROWNOUT_ENABLE);
`default_nettype wire

//--- testbench/reset_timeout_and_cause_flags_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_and_cause_flags_tb;
  import rst_seq_pkg::*;
  localparam int SLOW = 4; // shortened slow tick
  localparam int PLLC = 8; // shortened lock delay
  localparam int PWRD = 2048 * SLOW;
  typedef struct {osc_mode_e o; logic d; int e;} tcase_s;
  logic clk, rst, dly_off, stk_en, tick, bod, rsti, wdt, sfull, sunf, iwake, gh, gl;
  logic fwr, swwr, swwd, scwr, hold, core_rst, pc_ld, sw_en, pin_n, stall;
  logic [1:0] bcfg;
  logic [7:0] scd, scr, sv;
  logic [PC_W-1:0] pc, pc_val;
  osc_mode_e osc;
  pwr_mode_e pm;
  cause_flags_s fwd, exp_f, flags;
  logic [PC_W+6:0] notes[$]; // expected pc and flags
  logic [PC_W+6:0] nb;
  int n_errors, checks, n;
  // osc, delay off, minimum cycles to release
  tcase_s tc[5] = '{
    '{rc_osc_mode, 1'b1, 0},
    '{external_clock_mode, 1'b0, PWRD},
    '{crystal_osc_mode, 1'b1, 2048},
    '{crystal_pll_osc_mode, 1'b1, 2048 + PLLC},
    '{crystal_pll_osc_mode, 1'b0, PWRD + 2048 + PLLC}};

  reset_timeout_and_cause_flags #(.SLOW_TICK_CYCLES(SLOW), .PLL_CYCLES(PLLC)) DUT (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_OSC_MODE(osc),
    .I_POWER_DELAY_DISABLE_CFG(dly_off), .I_STACK_ERROR_RESET_EN(stk_en),
    .I_BROWNOUT_MODE_CFG(bcfg), .I_OSC_TICK(tick), .I_EXTERNAL_RESET_PIN_N(pin_n),
    .I_BROWNOUT_DETECT(bod), .I_RESET_INSTR(rsti), .I_WATCHDOG_TIMEOUT(wdt),
    .I_STACK_FULL(sfull), .I_STACK_UNDERFLOW(sunf), .I_INT_WAKE(iwake), .I_PWR_MODE(pm),
    .I_GLOBAL_INT_ENABLE_HIGH(gh), .I_GLOBAL_INT_ENABLE_LOW(gl), .I_PC(pc),
    .I_FLAGS_WR(fwr), .I_FLAGS_WDATA(fwd), .I_SW_BROWNOUT_WR(swwr),
    .I_SW_BROWNOUT_WDATA(swwd), .I_SCRATCH_WR(scwr), .I_SCRATCH_WDATA(scd),
    .O_CORE_RST(core_rst), .O_CORE_STALL(stall), .O_PC_LOAD(pc_ld), .O_PC_VALUE(pc_val),
    .O_CAUSE_FLAGS(flags), .O_SW_BROWNOUT_ENABLE(sw_en), .O_SCRATCH(scr));
  reset_pin_driver pin (.i_clk(clk), .i_hold(hold), .o_pin_n(pin_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // main oscillator: one tick every other cycle
  always @(posedge clk) tick <= ~tick;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // power-on pulse for six cycles with a given configuration
  task automatic por(input osc_mode_e o, input logic d);
    @(posedge clk);
    osc <= o;
    dly_off <= d;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  // cycles until the core leaves reset, bounded
  task automatic meas(output int c);
    c = 0;
    @(negedge clk);
    while (core_rst !== 1'b0 && c < 20000) begin
      @(negedge clk);
      c++;
    end
  endtask

  // software write of all cause flags
  task automatic wr(input cause_flags_s v);
    @(posedge clk);
    fwr <= 1'b1;
    fwd <= v;
    @(posedge clk);
    fwr <= 1'b0;
    exp_f = v;
  endtask

  // one event: k picks the source, v the expected pc kind, nt whether an answer is due
  task automatic ev(input int k, input pwr_mode_e m, input int v, input logic nt);
    logic [PC_W-1:0] p, e;
    p = PC_W'($urandom);
    @(posedge clk);
    pm <= m;
    pc <= p;
    @(posedge clk);
    case (k)
      0: rsti <= 1'b1;
      1: wdt <= 1'b1;
      2: sfull <= 1'b1;
      3: sunf <= 1'b1;
      4: iwake <= 1'b1;
      5: bod <= 1'b1;
      default: hold <= 1'b1;
    endcase
    e = (v == 0) ? RESET_VECTOR : (v == 1) ? p + PC_WAKE_STEP :
        (v == 2) ? INT_VECTOR_HIGH : INT_VECTOR_LOW;
    if (nt)
      notes.push_back({e, exp_f});
    @(posedge clk);
    {rsti, wdt, sfull, sunf, iwake, bod} <= '0;
    repeat (4) @(posedge clk);
    hold <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // watcher: every pc load consumes the oldest note
  always @(negedge clk) begin
    if (rst === 1'b0 && pc_ld === 1'b1) begin
      if (notes.size() == 0)
        check("unexpected pc load", 1'b1, 1'b0);
      else begin
        nb = notes.pop_front();
        check("pc value", pc_val, nb[PC_W+6:7]);
        check("cause flags", flags, nb[6:0]);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    {rst, dly_off, stk_en, tick, bod, rsti, wdt, sfull, sunf, iwake, gh, gl} = '0;
    {fwr, swwr, swwd, scwr, scd, pc, fwd} = '0;
    rst = 1'b1;
    hold = 1'b1;
    bcfg = 2'h1;
    osc = rc_osc_mode;
    pm = PWR_FULL;
    n_errors = 0;
    checks = 0;
    void'($urandom(55));
    // pin held low well past every time-out, then released
    por(crystal_pll_osc_mode, 1'b0);
    repeat (12000) @(negedge clk);
    check("held by pin", core_rst, 1'b1);
    @(posedge clk);
    hold <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("run at pin release", core_rst, 1'b0);
    // stage lengths per configuration
    for (int i = 0; i < 5; i++) begin
      por(tc[i].o, tc[i].d);
      meas(n);
      check("release time", n + 2 >= tc[i].e && n <= tc[i].e + 12, 1'b1);
    end
    por(rc_osc_mode, 1'b1);
    meas(n);
    exp_f = POR_FLAGS;
    check("power-on flags", flags, exp_f);
    check("power-on pc", pc_val, RESET_VECTOR);
    check("sw brown-out at power-on", sw_en, 1'b1);
    sv = 8'($urandom);
    @(posedge clk);
    scwr <= 1'b1;
    scd <= sv;
    @(posedge clk);
    scwr <= 1'b0;
    wr(7'h7f);
    exp_f.reset_instr_flag = 1'b0;
    ev(0, PWR_FULL, 0, 1'b1);
    exp_f.watchdog_timeout_flag = 1'b0;
    ev(1, PWR_FULL, 0, 1'b1);
    exp_f.watchdog_timeout_flag = 1'b1;
    ev(6, PWR_RUN, 0, 1'b1);
    exp_f = (exp_f | 7'h70) & 7'h7b;
    ev(5, PWR_FULL, 0, 1'b1);
    exp_f.watchdog_timeout_flag = 1'b0;
    ev(1, PWR_RUN, 0, 1'b1);
    exp_f = (exp_f | 7'h20) & 7'h6f;
    ev(6, PWR_SLEEP, 0, 1'b1);
    ev(6, PWR_FULL, 0, 1'b1);
    wr(7'h7c);
    exp_f = exp_f & 7'h4f;
    ev(1, PWR_SLEEP, 1, 1'b1);
    stk_en <= 1'b1;
    exp_f.stack_full_flag = 1'b1;
    ev(2, PWR_FULL, 0, 1'b1);
    exp_f.stack_underflow_flag = 1'b1;
    ev(3, PWR_FULL, 0, 1'b1);
    wr(7'h7c);
    stk_en <= 1'b0;
    exp_f.stack_underflow_flag = 1'b1;
    ev(3, PWR_FULL, 0, 1'b0);
    check("underflow flag only", flags, exp_f);
    // interrupt wake: high vector, low vector, then no enable
    for (int g = 0; g < 3; g++) begin
      wr(7'h7c);
      gh <= (g == 0);
      gl <= (g == 1);
      exp_f.power_down_flag = 1'b0;
      ev(4, PWR_IDLE, (g == 0) ? 2 : (g == 1) ? 3 : 1, 1'b1);
    end
    // ignored events must leave flags alone, seen at the next answer
    ev(2, PWR_FULL, 0, 1'b0);
    ev(4, PWR_FULL, 1, 1'b0);
    exp_f.reset_instr_flag = 1'b0;
    ev(0, PWR_SLEEP, 0, 1'b1);
    check("answers missing", notes.size(), 0);
    check("unreset register kept", scr, sv);
    check("sw brown-out kept", sw_en, 1'b1);
    @(posedge clk);
    bcfg <= 2'h0;
    @(negedge clk);
    check("sw brown-out off mode", sw_en, 1'b0);
    // crystal wake: pc+2 at once, then core stalled, not reset, for the start-up count
    por(crystal_osc_mode, 1'b1);
    meas(n);
    exp_f = POR_FLAGS & 7'h4f;
    ev(1, PWR_SLEEP, 1, 1'b1);
    @(negedge clk);
    check("wake stall", stall, 1'b1);
    check("wake not reset", core_rst, 1'b0);
    repeat (2100) @(negedge clk);
    check("wake stall done", stall, 1'b0);
    check("wake answer missing", notes.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
